/* File: common/srtf_pkg.sv */
// constants of the special relay timebase and flag block
package srtf_pkg;

    // register port shape
    localparam int ADDR_W = 8;
    localparam int DATA_W = 16;

    // register byte offsets
    localparam logic [7:0] OFS_STATUS   = 8'h00;
    localparam logic [7:0] OFS_CTRL     = 8'h04;
    localparam logic [7:0] OFS_PRESET   = 8'h08;
    localparam logic [7:0] OFS_IRQ_STAT = 8'h0C;
    localparam logic [7:0] OFS_IRQ_MASK = 8'h10;

    // status register fields
    localparam int NUM_TB      = 4;
    localparam int ST_TB_LSB   = 0;
    localparam int ST_FREQ_AT  = 4;
    localparam int ST_PAR_ERR  = 5;
    localparam int ST_PAR_OK   = 6;

    // control register fields
    localparam int CTRL_W         = 4;
    localparam int CTRL_FREQ_CMD  = 0;
    localparam int CTRL_DIR       = 1;
    localparam int CTRL_PID_FORCE = 2;
    localparam int CTRL_RT_EN     = 3;

    // interrupt status and mask fields
    localparam int IRQ_W      = 4;
    localparam int IRQ_PAR_ERR = 0;
    localparam int IRQ_PAR_OK  = 1;
    localparam int IRQ_FREQ_AT = 2;
    localparam int IRQ_MINUTE  = 3;

    // reset values
    localparam logic [CTRL_W-1:0] CTRL_RST   = 4'h0;
    localparam logic [IRQ_W-1:0]  MASK_RST   = 4'h0;
    localparam logic [DATA_W-1:0] PRESET_RST = 16'h0000;

    // clock and the common tick
    localparam int CLK_PERIOD_NS = 100;
    localparam int TICK_US       = 5000;
    localparam int TICK_CYCLES   = TICK_US * 1000 / CLK_PERIOD_NS;

    // half periods of the four timebases, in microseconds
    localparam int HALF_10MS_US  = 5000;
    localparam int HALF_100MS_US = 50000;
    localparam int HALF_1S_US    = 500000;
    localparam int HALF_1MIN_US  = 30000000;

    // half periods counted in common ticks
    localparam int TB_HALF_TICKS [NUM_TB] = '{
        HALF_10MS_US / TICK_US,
        HALF_100MS_US / TICK_US,
        HALF_1S_US / TICK_US,
        HALF_1MIN_US / TICK_US
    };

endpackage

/* File: src/srtf_wave_div.sv */
// square wave divider driven by the common tick
`timescale 1ns/1ps
module srtf_wave_div #(
    parameter int HALF_TICKS = 1
) (
    input  wire logic sys_clk_in,
    input  wire logic rst_b_in,
    input  wire logic tick_in,
    output logic      wave_out
);

    localparam int CW = $clog2(HALF_TICKS) + 1;
    localparam logic [CW-1:0] LAST = CW'(HALF_TICKS - 1);

    logic [CW-1:0] cnt_q;

    // count ticks, wrap at the half period; free running
    always_ff @(posedge sys_clk_in) begin
        if (!rst_b_in) begin
            cnt_q <= '0;
        end else if (tick_in) begin
            cnt_q <= (cnt_q == LAST) ? '0 : cnt_q + 1'b1;
        end
    end

    // flip the wave each half period so duty stays at one half
    always_ff @(posedge sys_clk_in) begin
        if (!rst_b_in) begin
            wave_out <= 1'b0;
        end else if (tick_in && cnt_q == LAST) begin
            wave_out <= ~wave_out;
        end
    end

endmodule // srtf_wave_div

/* File: src/srtf_top.sv */
// special relay timebases, drive status flags and program control bits
//
// Function
// RULE1: 10 ms timebase, 5 ms high, 5 low
// RULE2: 100 ms timebase, 50 ms each half
// RULE3: one second timebase, half second each half
// RULE4: one minute timebase, thirty seconds each half
// RULE5: frequency attained flag, valid with command bit
// RULE6: failed parameter access sets error flag
// RULE7: successful parameter write sets ok flag
// RULE8: program sets command bit to run frequency
// RULE9: program direction bit: clear forward, set reverse
// RULE10: force bit loads PID integral from preset
// RULE11: realtime bit starts fieldbus realtime control
// RULE12: timebases free run from common tick
`timescale 1ns/1ps
module srtf_top
    import srtf_pkg::*;
#(
    parameter int TICK_CYCLES = srtf_pkg::TICK_CYCLES
) (
    input  wire logic                        sys_clk_in,
    input  wire logic                        rst_b_in,
    input  wire logic [srtf_pkg::ADDR_W-1:0] reg_addr_in,
    input  wire logic [srtf_pkg::DATA_W-1:0] reg_wdata_in,
    input  wire logic                        reg_wr_in,
    input  wire logic                        reg_rd_in,
    output logic      [srtf_pkg::DATA_W-1:0] reg_rdata_out,
    input  wire logic                        freq_at_set_in,
    input  wire logic                        param_done_in,
    input  wire logic                        param_write_in,
    input  wire logic                        param_fail_in,
    output logic      [srtf_pkg::NUM_TB-1:0] tick_bits_out,
    output logic                             freq_command_out,
    output logic                             direction_select_out,
    output logic                             pid_integral_load_out,
    output logic      [srtf_pkg::DATA_W-1:0] pid_integral_value_out,
    output logic                             fieldbus_rt_enable_out,
    output logic                             fieldbus_rt_start_out,
    output logic                             irq_out
);

    import srtf_pkg::*;

    localparam int TICK_W = $clog2(TICK_CYCLES) + 1;
    localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(TICK_CYCLES - 1);

    // ------------------------------------------------------------------
    // common tick and timebases
    // ------------------------------------------------------------------
    logic [TICK_W-1:0] tick_cnt_q;
    logic              tick_q;
    logic [NUM_TB-1:0] tb_wave;

    // one-cycle tick every TICK_CYCLES; nothing software does touches it
    always_ff @(posedge sys_clk_in) begin
        if (!rst_b_in) begin
            tick_cnt_q <= '0;
            tick_q     <= 1'b0;
        end else begin
            tick_q     <= (tick_cnt_q == TICK_LAST); // RULE12
            tick_cnt_q <= (tick_cnt_q == TICK_LAST) ? '0
                          : tick_cnt_q + 1'b1;
        end
    end

    // one divider per timebase; all share the tick so edges line up
    for (genvar i = 0; i < NUM_TB; i++) begin : g_tb
        srtf_wave_div #(
            .HALF_TICKS (TB_HALF_TICKS[i])
        ) u_div (
            .sys_clk_in (sys_clk_in),
            .rst_b_in   (rst_b_in),
            .tick_in    (tick_q),
            .wave_out   (tb_wave[i])
        );
    end

    // timebase pins; a copy so outputs come straight from flops
    always_ff @(posedge sys_clk_in) begin
        if (!rst_b_in) begin
            tick_bits_out <= '0;
        end else begin
            tick_bits_out <= tb_wave; // RULE1 RULE2 RULE3 RULE4
        end
    end

    // ------------------------------------------------------------------
    // drive status inputs
    // ------------------------------------------------------------------
    logic freq_sync1_q;
    logic freq_sync2_q;

    // the at-set-frequency level comes from the motor side, not our clock
    always_ff @(posedge sys_clk_in) begin
        if (!rst_b_in) begin
            freq_sync1_q <= 1'b0;
            freq_sync2_q <= 1'b0;
        end else begin
            freq_sync1_q <= freq_at_set_in;
            freq_sync2_q <= freq_sync1_q;
        end
    end

    // ------------------------------------------------------------------
    // register state
    // ------------------------------------------------------------------
    logic [CTRL_W-1:0] ctrl_q;
    logic [DATA_W-1:0] preset_q;
    logic [IRQ_W-1:0]  irq_stat_q;
    logic [IRQ_W-1:0]  irq_mask_q;
    logic              freq_at_q;
    logic              par_err_q;
    logic              par_ok_q;
    logic              min_prev_q;
    logic              rt_prev_q;

    logic              wr_ctrl;
    logic              wr_preset;
    logic              wr_irq_stat;
    logic              wr_irq_mask;

    assign wr_ctrl     = reg_wr_in && reg_addr_in == OFS_CTRL;
    assign wr_preset   = reg_wr_in && reg_addr_in == OFS_PRESET;
    assign wr_irq_stat = reg_wr_in && reg_addr_in == OFS_IRQ_STAT;
    assign wr_irq_mask = reg_wr_in && reg_addr_in == OFS_IRQ_MASK;

    // control bits: frequency command, direction, PID force, realtime
    always_ff @(posedge sys_clk_in) begin
        if (!rst_b_in) begin
            ctrl_q <= CTRL_RST;
        end else if (wr_ctrl) begin
            ctrl_q <= reg_wdata_in[CTRL_W-1:0]; // RULE8 RULE9
        end
    end

    // preset word for the PID integral
    always_ff @(posedge sys_clk_in) begin
        if (!rst_b_in) begin
            preset_q <= PRESET_RST;
        end else if (wr_preset) begin
            preset_q <= reg_wdata_in;
        end
    end

    // attained only counts while the program asks for the set frequency;
    // with the command off the drive heads to zero and the flag is moot
    always_ff @(posedge sys_clk_in) begin
        if (!rst_b_in) begin
            freq_at_q <= 1'b0;
        end else begin
            freq_at_q <= freq_sync2_q && ctrl_q[CTRL_FREQ_CMD]; // RULE5
        end
    end

    // outcome of the last parameter access; kept until the next one
    always_ff @(posedge sys_clk_in) begin
        if (!rst_b_in) begin
            par_err_q <= 1'b0;
            par_ok_q  <= 1'b0;
        end else if (param_done_in) begin
            par_err_q <= param_fail_in; // RULE6
            par_ok_q  <= param_write_in && !param_fail_in; // RULE7
        end
    end

    // ------------------------------------------------------------------
    // interrupts
    // ------------------------------------------------------------------
    logic [IRQ_W-1:0] irq_set;
    logic [IRQ_W-1:0] irq_clr;

    // events: access error, write ok, attained rise, minute edge
    always_comb begin
        irq_set              = '0;
        irq_set[IRQ_PAR_ERR] = param_done_in && param_fail_in;
        irq_set[IRQ_PAR_OK]  = param_done_in && param_write_in
                               && !param_fail_in;
        irq_set[IRQ_FREQ_AT] = freq_sync2_q && ctrl_q[CTRL_FREQ_CMD]
                               && !freq_at_q;
        irq_set[IRQ_MINUTE]  = tb_wave[NUM_TB-1] ^ min_prev_q;
        irq_clr              = wr_irq_stat ? reg_wdata_in[IRQ_W-1:0] : '0;
    end

    // remember the minute wave to spot its edges
    always_ff @(posedge sys_clk_in) begin
        if (!rst_b_in) begin
            min_prev_q <= 1'b0;
        end else begin
            min_prev_q <= tb_wave[NUM_TB-1];
        end
    end

    // write one to clear; an event in the clearing cycle still lands
    always_ff @(posedge sys_clk_in) begin
        if (!rst_b_in) begin
            irq_stat_q <= '0;
        end else begin
            irq_stat_q <= (irq_stat_q & ~irq_clr) | irq_set;
        end
    end

    // mask register, same layout as the status
    always_ff @(posedge sys_clk_in) begin
        if (!rst_b_in) begin
            irq_mask_q <= MASK_RST;
        end else if (wr_irq_mask) begin
            irq_mask_q <= reg_wdata_in[IRQ_W-1:0];
        end
    end

    // level interrupt, one cycle behind the status bits
    always_ff @(posedge sys_clk_in) begin
        if (!rst_b_in) begin
            irq_out <= 1'b0;
        end else begin
            irq_out <= |(irq_stat_q & irq_mask_q);
        end
    end

    // ------------------------------------------------------------------
    // outputs toward the drive firmware
    // ------------------------------------------------------------------

    // plain control levels
    always_ff @(posedge sys_clk_in) begin
        if (!rst_b_in) begin
            freq_command_out     <= 1'b0;
            direction_select_out <= 1'b0;
        end else begin
            freq_command_out     <= ctrl_q[CTRL_FREQ_CMD]; // RULE8
            direction_select_out <= ctrl_q[CTRL_DIR]; // RULE9
        end
    end

    // while forcing, the integral is held at the preset every cycle;
    // clear the bit and the controller integrates from there unchanged
    always_ff @(posedge sys_clk_in) begin
        if (!rst_b_in) begin
            pid_integral_load_out  <= 1'b0;
            pid_integral_value_out <= PRESET_RST;
        end else begin
            pid_integral_load_out  <= ctrl_q[CTRL_PID_FORCE]; // RULE10
            pid_integral_value_out <= preset_q; // RULE10
        end
    end

    // realtime level plus a start pulse on its rising edge
    always_ff @(posedge sys_clk_in) begin
        if (!rst_b_in) begin
            rt_prev_q              <= 1'b0;
            fieldbus_rt_enable_out <= 1'b0;
            fieldbus_rt_start_out  <= 1'b0;
        end else begin
            rt_prev_q              <= ctrl_q[CTRL_RT_EN];
            fieldbus_rt_enable_out <= ctrl_q[CTRL_RT_EN]; // RULE11
            fieldbus_rt_start_out  <= ctrl_q[CTRL_RT_EN]
                                      && !rt_prev_q; // RULE11
        end
    end

    // ------------------------------------------------------------------
    // read port: data in the cycle after the strobe, zero otherwise
    // ------------------------------------------------------------------
    logic [DATA_W-1:0] rd_mux;

    always_comb begin
        rd_mux = '0;
        case (reg_addr_in)
            OFS_STATUS: begin
                rd_mux[ST_TB_LSB +: NUM_TB] = tick_bits_out;
                rd_mux[ST_FREQ_AT]          = freq_at_q;
                rd_mux[ST_PAR_ERR]          = par_err_q;
                rd_mux[ST_PAR_OK]           = par_ok_q;
            end
            OFS_CTRL:     rd_mux[CTRL_W-1:0] = ctrl_q;
            OFS_PRESET:   rd_mux             = preset_q;
            OFS_IRQ_STAT: rd_mux[IRQ_W-1:0]  = irq_stat_q;
            OFS_IRQ_MASK: rd_mux[IRQ_W-1:0]  = irq_mask_q;
            default:      rd_mux             = '0;
        endcase
    end

    // unmapped addresses read zero rather than holding the last word
    always_ff @(posedge sys_clk_in) begin
        if (!rst_b_in) begin
            reg_rdata_out <= '0;
        end else begin
            reg_rdata_out <= reg_rd_in ? rd_mux : '0;
        end
    end

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (!rst_b_in);

    // the fastest wave flips on every tick, one half per tick
    property p_tb10;
        tick_q |=> ##1 (tick_bits_out[0] != $past(tick_bits_out[0]));
    endproperty
    a_tb10: assert property (p_tb10) // RULE1
        else $error("10 ms timebase did not flip on tick");

    // the 100 ms wave only moves right after a tick
    property p_tb100;
        $changed(tb_wave[1]) |-> $past(tick_q);
    endproperty
    a_tb100: assert property (p_tb100) // RULE2
        else $error("100 ms timebase moved without a tick");

    // each second edge coincides with a 100 ms edge
    property p_tb1s;
        $changed(tb_wave[2]) |-> $changed(tb_wave[1]);
    endproperty
    a_tb1s: assert property (p_tb1s) // RULE3
        else $error("1 s timebase edge off the 100 ms grid");

    // each minute edge coincides with a second edge
    property p_tb1min;
        $changed(tb_wave[3]) |-> $changed(tb_wave[2]);
    endproperty
    a_tb1min: assert property (p_tb1min) // RULE4
        else $error("1 min timebase edge off the 1 s grid");

    // attained never shows in the cycle after the command bit is off
    property p_freq_at;
        !ctrl_q[CTRL_FREQ_CMD] |=> !freq_at_q;
    endproperty
    a_freq_at: assert property (p_freq_at) // RULE5
        else $error("frequency attained without the command bit");

    // a failed access raises error and drops ok
    property p_par_err;
        param_done_in && param_fail_in |=> par_err_q && !par_ok_q;
    endproperty
    a_par_err: assert property (p_par_err) // RULE6
        else $error("failed parameter access not flagged");

    // a good write raises ok, clears error, and both hold for the next two cycles
    sequence s_write_ok;
        param_done_in && param_write_in && !param_fail_in;
    endsequence
    property p_par_ok;
        s_write_ok |=> (par_ok_q && !par_err_q) throughout
            (!param_done_in [*2]);
    endproperty
    a_par_ok: assert property (p_par_ok) // RULE7
        else $error("parameter write ok flag wrong");

    // forcing hands the preset to the controller one cycle on
    property p_pid;
        ctrl_q[CTRL_PID_FORCE] && $stable(preset_q) |=>
            pid_integral_load_out && pid_integral_value_out ==
            $past(preset_q);
    endproperty
    a_pid: assert property (p_pid) // RULE10
        else $error("PID integral preset not presented");

    // enabling realtime gives exactly one start pulse
    sequence s_rt_pulse;
        fieldbus_rt_start_out ##1 !fieldbus_rt_start_out;
    endsequence
    property p_rt;
        $rose(ctrl_q[CTRL_RT_EN]) |=> s_rt_pulse;
    endproperty
    a_rt: assert property (p_rt) // RULE11
        else $error("realtime start pulse missing or too long");

    // the tick arrives exactly at the end of the count
    property p_tick;
        tick_q |-> $past(tick_cnt_q) == TICK_LAST;
    endproperty
    a_tick: assert property (p_tick) // RULE12
        else $error("common tick out of step with its counter");

endmodule // srtf_top

/* File: dv/srtf_prog_model.sv */
// program-side model: register master and drive parameter reports
`timescale 1ns/1ps
module srtf_prog_model (
    input  wire logic                        sys_clk_in,
    input  wire logic [srtf_pkg::DATA_W-1:0] rdata_in,
    output logic      [srtf_pkg::ADDR_W-1:0] addr_out,
    output logic      [srtf_pkg::DATA_W-1:0] wdata_out,
    output logic                             wr_out,
    output logic                             rd_out,
    output logic                             done_out,
    output logic                             write_out,
    output logic                             fail_out
);
    import srtf_pkg::*;

    // idle bus at time zero
    initial begin
        addr_out  = 8'h00;
        wdata_out = 16'h0000;
        wr_out    = 1'b0;
        rd_out    = 1'b0;
        done_out  = 1'b0;
        write_out = 1'b0;
        fail_out  = 1'b0;
    end

    // one-cycle write; released data is inverted so stale values never match
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        addr_out  <= a;
        wdata_out <= d;
        wr_out    <= 1'b1;
        @(posedge sys_clk_in);
        wr_out    <= 1'b0;
        wdata_out <= ~d;
        @(posedge sys_clk_in);
    endtask

    // one-cycle read; data is taken in the cycle after the strobe only
    task automatic rd(input logic [7:0] a, output logic [15:0] d);
        addr_out <= a;
        rd_out   <= 1'b1;
        @(posedge sys_clk_in);
        rd_out   <= 1'b0;
        addr_out <= ~a;
        @(posedge sys_clk_in);
        d = rdata_in;
    endtask

    // drive reports a finished parameter access with a single done pulse
    task automatic param(input logic w, input logic f);
        done_out  <= 1'b1;
        write_out <= w;
        fail_out  <= f;
        @(posedge sys_clk_in);
        done_out  <= 1'b0;
        write_out <= ~w;
        fail_out  <= ~f;
        @(posedge sys_clk_in);
    endtask
endmodule // srtf_prog_model

/* File: dv/tb_special_relay_timebase_flags.sv */
// self-checking bench for the relay timebase and flag block
`timescale 1ns/1ps
module tb_special_relay_timebase_flags;
    import srtf_pkg::*;
    localparam int TCK = 4;

    logic                sys_clk_in     = 1'b0;
    logic                rst_b_in       = 1'b0;
    logic                freq_at_set_in = 1'b0;
    logic [ADDR_W-1:0]   reg_addr;
    logic [DATA_W-1:0]   reg_wdata;
    logic                reg_wr;
    logic                reg_rd;
    logic [DATA_W-1:0]   reg_rdata_out;
    logic                param_done;
    logic                param_write;
    logic                param_fail;
    logic [NUM_TB-1:0]   tick_bits_out;
    logic                freq_command_out;
    logic                direction_select_out;
    logic                pid_integral_load_out;
    logic [DATA_W-1:0]   pid_integral_value_out;
    logic                fieldbus_rt_enable_out;
    logic                fieldbus_rt_start_out;
    logic                irq_out;
    int                  bad_count = 0;
    int                  checked   = 0;
    int                  rt_rises  = 0;
    int                  rt_pulses = 0;
    int                  cnt [NUM_TB];
    int                  seen [NUM_TB];
    logic [NUM_TB-1:0]   prev_tb;
    logic [3:0]          exp_ctrl  = 4'h0;
    logic [15:0]         exp_ist   = 16'h0000;
    logic [15:0]         exp_mask  = 16'h0000;
    logic [15:0]         rdat;
    logic [15:0]         d;
    logic [3:0]          v;
    logic [7:0]          offs [6] = '{OFS_STATUS, OFS_CTRL, OFS_PRESET,
                                      OFS_IRQ_STAT, OFS_IRQ_MASK, 8'h14};
    logic [1:0]          pa [5] = '{2'h2, 2'h3, 2'h1, 2'h0, 2'h2};

    always #50 sys_clk_in = ~sys_clk_in;

    srtf_prog_model i_prog (
        .sys_clk_in (sys_clk_in),
        .rdata_in   (reg_rdata_out),
        .addr_out   (reg_addr),
        .wdata_out  (reg_wdata),
        .wr_out     (reg_wr),
        .rd_out     (reg_rd),
        .done_out   (param_done),
        .write_out  (param_write),
        .fail_out   (param_fail)
    );

    // short tick keeps the minute wave within the run
    srtf_top #(.TICK_CYCLES(TCK)) i_dut (
        .sys_clk_in             (sys_clk_in),
        .rst_b_in               (rst_b_in),
        .reg_addr_in            (reg_addr),
        .reg_wdata_in           (reg_wdata),
        .reg_wr_in              (reg_wr),
        .reg_rd_in              (reg_rd),
        .reg_rdata_out          (reg_rdata_out),
        .freq_at_set_in         (freq_at_set_in),
        .param_done_in          (param_done),
        .param_write_in         (param_write),
        .param_fail_in          (param_fail),
        .tick_bits_out          (tick_bits_out),
        .freq_command_out       (freq_command_out),
        .direction_select_out   (direction_select_out),
        .pid_integral_load_out  (pid_integral_load_out),
        .pid_integral_value_out (pid_integral_value_out),
        .fieldbus_rt_enable_out (fieldbus_rt_enable_out),
        .fieldbus_rt_start_out  (fieldbus_rt_start_out),
        .irq_out                (irq_out)
    );

    task automatic chk(input logic [15:0] got, input logic [15:0] exp,
                       input string what);
        checked++;
        if (got !== exp) begin
            bad_count++;
            $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    task automatic rchk(input logic [7:0] a, input logic [15:0] m,
                        input logic [15:0] e);
        i_prog.rd(a, rdat);
        chk(rdat & m, e & m, "register read");
    endtask

    // irq is registered behind status and mask, so let it settle first
    task automatic ichk;
        repeat (3) @(posedge sys_clk_in);
        chk({15'h0000, irq_out}, {15'h0000, (exp_ist & exp_mask) != 0}, "irq");
    endtask

    task automatic results;
        $display("checks %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // measure each half period of each wave after its first edge; also count start pulses
    always @(posedge sys_clk_in) begin
        if (!rst_b_in) begin
            for (int i = 0; i < NUM_TB; i++) begin
                cnt[i]  = 0;
                seen[i] = 0;
            end
        end else begin
            for (int i = 0; i < NUM_TB; i++) begin
                if (tick_bits_out[i] !== prev_tb[i]) begin
                    if (seen[i] > 0) begin
                        checked++;
                        if (cnt[i] != TB_HALF_TICKS[i] * TCK) begin
                            bad_count++;
                            $display("[ERR] %0t wave %0d half %0d", $time, i,
                                     cnt[i]);
                        end
                    end
                    seen[i]++;
                    cnt[i] = 1;
                end else begin
                    cnt[i]++;
                end
            end
            if (fieldbus_rt_start_out === 1'b1) rt_pulses++;
        end
        prev_tb = tick_bits_out;
    end

    initial begin
        void'($urandom(32'h9A9F));
        repeat (16) @(posedge sys_clk_in);
        rst_b_in <= 1'b1;
        @(posedge sys_clk_in);
        // reset values, unmapped place reads zero
        foreach (offs[k]) begin
            rchk(offs[k], (k == 0) ? 16'hFFF0 : 16'hFFFF, 16'h0000);
        end
        i_prog.wr(OFS_STATUS, 16'hFFFF);
        rchk(OFS_STATUS, 16'hFFF0, 16'h0000);
        // every control value in order, then random ones
        for (int k = 0; k < 24; k++) begin
            v = (k < 16) ? k[3:0] : 4'($urandom);
            if (v[3] && !exp_ctrl[3]) rt_rises++;
            exp_ctrl = v;
            i_prog.wr(OFS_CTRL, {12'h000, v});
            rchk(OFS_CTRL, 16'hFFFF, {12'h000, v});
            chk({12'h000, fieldbus_rt_enable_out, pid_integral_load_out,
                 direction_select_out, freq_command_out},
                {12'h000, v}, "control outputs");
        end
        // preset word feeds the integral
        repeat (4) begin
            d = 16'($urandom);
            i_prog.wr(OFS_PRESET, d);
            rchk(OFS_PRESET, 16'hFFFF, d);
            chk(pid_integral_value_out, d, "preset");
        end
        // parameter access outcomes, a clean read clears both flags
        foreach (pa[k]) begin
            i_prog.param(pa[k][1], pa[k][0]);
            exp_ist[0] = exp_ist[0] | pa[k][0];
            exp_ist[1] = exp_ist[1] | (pa[k][1] & ~pa[k][0]);
            rchk(OFS_STATUS, 16'h0060,
                 {9'h000, pa[k][1] & ~pa[k][0], pa[k][0], 5'h00});
        end
        // attained flag only counts while the command bit is on
        i_prog.wr(OFS_CTRL, 16'h0000);
        freq_at_set_in <= 1'b1;
        repeat (5) @(posedge sys_clk_in);
        rchk(OFS_STATUS, 16'h0010, 16'h0000);
        i_prog.wr(OFS_CTRL, 16'h0001);
        repeat (5) @(posedge sys_clk_in);
        rchk(OFS_STATUS, 16'h0010, 16'h0010);
        exp_ist[2] = 1'b1;
        // sticky status, mask and write-one-to-clear
        rchk(OFS_IRQ_STAT, 16'h0007, exp_ist);
        ichk();
        exp_mask = 16'h0007;
        i_prog.wr(OFS_IRQ_MASK, exp_mask);
        ichk();
        rchk(OFS_IRQ_MASK, 16'hFFFF, exp_mask);
        i_prog.wr(OFS_IRQ_STAT, exp_ist);
        exp_ist = 16'h0000;
        rchk(OFS_IRQ_STAT, 16'h0007, exp_ist);
        ichk();
        // wait for two edges of the minute wave, then its interrupt
        for (int k = 0; k < 60000 && seen[3] < 2; k++) @(posedge sys_clk_in);
        chk(16'(seen[3]), 16'h0002, "minute edges");
        rchk(OFS_IRQ_STAT, 16'h0008, 16'h0008);
        exp_ist  = 16'h0008;
        exp_mask = 16'h0008;
        i_prog.wr(OFS_IRQ_MASK, exp_mask);
        ichk();
        chk(16'(rt_pulses), 16'(rt_rises), "start pulses");
        results();
    end

    // run needs about 50000 cycles; cut off well beyond that
    initial begin
        #(100 * 80000);
        bad_count++;
        $display("[ERR] %0t watchdog expired", $time);
        results();
    end
endmodule // tb_special_relay_timebase_flags
